// ---- design/e1lcr_pkg.sv ----
// Package for the E1 line clock recovery and jitter attenuator block.
// Assumes a single 50 MHz clock domain and AXI4-Lite register access.
package e1lcr_pkg;
    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] LIC_OFFSET = 8'h18; // line_interface_control
    localparam logic [7:0] RIR_OFFSET = 8'h1c; // receive_info_register
    localparam logic [7:0] LIC_RESET = 8'h00;
    // Field positions of line_interface_control
    localparam int BOS_HI = 7;
    localparam int BOS_LO = 5;
    localparam int JSS_BIT = 3;
    localparam int JDS_BIT = 2;
    localparam int JDIS_BIT = 1;
    // Field positions of receive_info_register
    localparam int JLT_BIT = 5;
    localparam int RCL_BIT = 0;
    // ==========================================================
    // Oversampling and divider figures
    localparam int OVS_RATIO = 16;
    localparam logic [4:0] DIV_NOM = 5'h10;
    localparam logic [4:0] DIV_FAST = 5'h0f;
    localparam logic [4:0] DIV_SLOW = 5'h11;
    localparam int DEPTH_DEEP = 128;
    localparam int DEPTH_SHALLOW = 32;
    // Trip margins in bits of fill away from centre
    localparam logic [7:0] TRIP_DEEP = 8'h3c;   // 120 UIpp half span
    localparam logic [7:0] TRIP_SHALLOW = 8'h0e; // 28 UIpp half span
    // Carrier loss: oversample ticks without a pulse
    localparam logic [9:0] RCL_LIMIT = 10'h200;
    // Master clock phase step for 2.048 MHz x16 from 50 MHz (accumulator 16 bit)
    localparam logic [15:0] NCO_STEP = 16'ha7c6;
    // ==========================================================
    // Build-out codes
    typedef enum logic [2:0] {
        E1LCR_BO_75N = 3'h0,
        E1LCR_BO_120N = 3'h1,
        E1LCR_BO_75P = 3'h2,
        E1LCR_BO_120P = 3'h3,
        E1LCR_BO_75H15 = 3'h4,
        E1LCR_BO_120H = 3'h5,
        E1LCR_BO_75H36 = 3'h6,
        E1LCR_BO_RSVD = 3'h7
    } e1lcr_bo_t;
    // Waveshaper setting carried together
    typedef struct packed {
        logic ohm120;
        logic protect;
        logic high_rl;
        logic ratio136;
        logic not_advised;
    } e1lcr_shape_t;
    // Divider states
    typedef enum logic [2:0] {
        E1LCR_D16 = 3'b001,
        E1LCR_D15 = 3'b010,
        E1LCR_D17 = 3'b100
    } e1lcr_div_t;
endpackage

// ---- design/e1lcr_top.sv ----
// E1 line interface digital core: clock recovery, recovered clock
// selection, build-out decode and jitter attenuator.
// Assumes line inputs and transmit clock are synchronous to CLK.
`timescale 1ns/100ps
module e1lcr_top
    import e1lcr_pkg::*;
(
    input wire logic CLK,
    input wire logic RSTN,
    // AXI4-Lite slave
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // Line side
    input wire logic RECEIVE_LINE_POSITIVE,
    input wire logic RECEIVE_LINE_NEGATIVE,
    input wire logic TRANSMIT_CLOCK_IN,
    input wire logic TX_DATA_IN,
    // Framer side and status
    output logic RECOVERED_CLOCK_OUT,
    output logic RX_DATA_OUT,
    output logic TRANSMIT_CLOCK,
    output logic TX_DATA_OUT,
    output logic RECEIVE_CARRIER_LOSS,
    output e1lcr_pkg::e1lcr_shape_t WAVE_SHAPE
);
    import e1lcr_pkg::*;

    // ==========================================================
    // Register bus
    logic [7:0] lic_q, lic_d;
    logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [1:0] bresp_q, rresp_q;
    logic jlt_q, rcl_q, lic_wr_q;

    function automatic logic addr_ok(input logic [7:0] a);
        return (a == LIC_OFFSET) || (a == RIR_OFFSET);
    endfunction

    wire logic do_write = aw_hold_q && w_hold_q && !bvalid_q;
    wire logic [31:0] rir_word = {26'h0, jlt_q, 4'h0, rcl_q};
    wire logic [31:0] rd_word = (ARADDR == LIC_OFFSET) ? {24'h0, lic_q} :
                                (ARADDR == RIR_OFFSET) ? rir_word : 32'h0;
    // side select / depth / disable / build-out field
    wire logic lic_hit = do_write && (awaddr_q == LIC_OFFSET);
    assign lic_d = lic_hit ? wdata_q[7:0] : lic_q;
    wire logic ja_side_select = lic_q[JSS_BIT];
    wire logic ja_depth_select = lic_q[JDS_BIT];
    wire logic ja_disable = lic_q[JDIS_BIT];
    wire e1lcr_bo_t build_out_select = e1lcr_bo_t'(lic_q[BOS_HI:BOS_LO]);

    assign AWREADY = !aw_hold_q;
    assign WREADY = !w_hold_q;
    assign ARREADY = !rvalid_q;
    assign BVALID = bvalid_q;
    assign BRESP = bresp_q;
    assign RVALID = rvalid_q;
    assign RDATA = rdata_q;
    assign RRESP = rresp_q;

    // Write channel capture and response
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            bvalid_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            bresp_q <= 2'h0;
            lic_q <= LIC_RESET;
            lic_wr_q <= 1'b0;
        end else begin
            lic_q <= lic_d;
            lic_wr_q <= lic_hit; // Recentres the attenuator one cycle later
            if (AWVALID && AWREADY) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= AWADDR;
            end
            if (WVALID && WREADY) begin
                w_hold_q <= 1'b1;
                wdata_q <= WDATA;
            end
            if (do_write) begin
                bvalid_q <= 1'b1;
                bresp_q <= addr_ok(awaddr_q) ? 2'h0 : 2'h2;
            end else if (bvalid_q && BREADY) begin
                bvalid_q <= 1'b0;
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
            end
        end
    end

    // Read channel
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= 2'h0;
        end else if (ARVALID && ARREADY) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= addr_ok(ARADDR) ? 2'h0 : 2'h2;
        end else if (rvalid_q && RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    // ==========================================================
    // Build-out decode
    // normal and protected / high return loss / early silicon
    always_comb begin
        WAVE_SHAPE = '0;
        unique case (build_out_select)
            E1LCR_BO_75N: WAVE_SHAPE.not_advised = 1'b1;
            E1LCR_BO_120N: WAVE_SHAPE.ohm120 = 1'b1;
            E1LCR_BO_75P: WAVE_SHAPE.protect = 1'b1;
            E1LCR_BO_120P: WAVE_SHAPE = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
            E1LCR_BO_75H15: WAVE_SHAPE.high_rl = 1'b1;
            E1LCR_BO_120H: WAVE_SHAPE = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
            E1LCR_BO_75H36: WAVE_SHAPE = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
            E1LCR_BO_RSVD: WAVE_SHAPE = '0;
        endcase
    end

    // ==========================================================
    // Oversampling clock: 2.048 MHz x 16 tick from a phase accumulator
    logic [16:0] nco_q;
    logic [3:0] mck_ph_q;
    wire logic ovs_tick = nco_q[16];
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            nco_q <= 17'h0;
            mck_ph_q <= 4'h0;
        end else begin
            nco_q <= {1'b0, nco_q[15:0]} + {1'b0, NCO_STEP};
            if (ovs_tick) mck_ph_q <= mck_ph_q + 4'h1;
        end
    end
    wire logic master_clk = mck_ph_q[3];

    // ==========================================================
    // Clock and data recovery at sixteen ticks per bit
    logic pulse_q, prev_pulse_q, rec_clk_q, rx_bit_q, rx_strobe_q;
    logic [3:0] cdr_ph_q;
    logic [9:0] idle_q;
    wire logic line_pulse = RECEIVE_LINE_POSITIVE | RECEIVE_LINE_NEGATIVE;
    wire logic pulse_edge = pulse_q && !prev_pulse_q;
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            pulse_q <= 1'b0;
            prev_pulse_q <= 1'b0;
            cdr_ph_q <= 4'h0;
            rec_clk_q <= 1'b0;
            rx_bit_q <= 1'b0;
            rx_strobe_q <= 1'b0;
            idle_q <= 10'h0;
            rcl_q <= 1'b0;
        end else begin
            rx_strobe_q <= 1'b0;
            if (ovs_tick) begin
                pulse_q <= line_pulse;
                prev_pulse_q <= pulse_q;
                // phase realigned on each line pulse
                cdr_ph_q <= pulse_edge ? 4'h1 : cdr_ph_q + 4'h1;
                // Short high phase as recovered clock is edge aligned
                rec_clk_q <= (cdr_ph_q >= 4'h4) && (cdr_ph_q < 4'hb);
                // Sample inside the mark, which fills the first half bit
                if (cdr_ph_q == 4'h4) begin
                    rx_bit_q <= pulse_q | prev_pulse_q;
                    rx_strobe_q <= 1'b1;
                end
                if (pulse_edge) begin
                    idle_q <= 10'h0;
                    rcl_q <= 1'b0;
                end else if (idle_q == RCL_LIMIT) begin
                    rcl_q <= 1'b1;
                end else begin
                    idle_q <= idle_q + 10'h1;
                end
            end
        end
    end

    // ==========================================================
    // Jitter attenuator FIFO with adaptive read divider
    logic [127:0] ja_mem_q;
    logic [6:0] wr_ptr_q, rd_ptr_q;
    logic [4:0] div_cnt_q;
    logic smooth_clk_q, ja_out_q, transmit_clock_prev_q;
    e1lcr_div_t div_q;
    wire logic ja_rx = !ja_disable && !ja_side_select;
    wire logic ja_tx = !ja_disable && ja_side_select;
    wire logic transmit_clock_rise = TRANSMIT_CLOCK_IN && !transmit_clock_prev_q;
    // write strobe chosen by side / gaps only pause writes
    wire logic ja_wr = ja_rx ? rx_strobe_q : (ja_tx && transmit_clock_rise);
    wire logic ja_in = ja_rx ? rx_bit_q : TX_DATA_IN;
    wire logic [6:0] ptr_mask = ja_depth_select ? 7'h1f : 7'h7f;
    wire logic [6:0] fill = (wr_ptr_q - rd_ptr_q) & ptr_mask;
    wire logic [7:0] centre = ja_depth_select ? 8'h10 : 8'h40;
    wire logic [7:0] margin = ja_depth_select ? TRIP_SHALLOW : TRIP_DEEP;
    wire logic too_full = {1'b0, fill} > centre + margin;
    wire logic too_empty = {1'b0, fill} + margin < centre;
    // divide by 15 when filling, 17 when draining
    wire logic [4:0] div_len = (div_q == E1LCR_D15) ? DIV_FAST :
                               (div_q == E1LCR_D17) ? DIV_SLOW : DIV_NOM;
    wire logic div_end = ovs_tick && (div_cnt_q >= div_len - 5'h1);
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            ja_mem_q <= '0;
            wr_ptr_q <= 7'h40; // Half of the deep buffer
            rd_ptr_q <= 7'h0;
            div_cnt_q <= 5'h0;
            smooth_clk_q <= 1'b0;
            ja_out_q <= 1'b0;
            transmit_clock_prev_q <= 1'b0;
            div_q <= E1LCR_D16;
            jlt_q <= 1'b0;
        end else begin
            transmit_clock_prev_q <= TRANSMIT_CLOCK_IN;
            // Restart half full when disabled or just after a control write
            if (ja_disable || lic_wr_q) begin
                wr_ptr_q <= centre[6:0];
                rd_ptr_q <= 7'h0;
                div_q <= E1LCR_D16;
            end else begin
                if (ja_wr) begin
                    ja_mem_q[wr_ptr_q & ptr_mask] <= ja_in;
                    wr_ptr_q <= (wr_ptr_q + 7'h1) & ptr_mask;
                end
                if (div_end) begin
                    ja_out_q <= ja_mem_q[rd_ptr_q & ptr_mask];
                    rd_ptr_q <= (rd_ptr_q + 7'h1) & ptr_mask;
                    div_q <= too_full ? E1LCR_D15 : too_empty ? E1LCR_D17 : E1LCR_D16;
                end
            end
            if (ovs_tick) begin
                // smoothed clock from divided 32.768 MHz rate
                div_cnt_q <= div_end ? 5'h0 : div_cnt_q + 5'h1;
                smooth_clk_q <= (div_cnt_q < DIV_NOM / 5'h2);
            end
            jlt_q <= !ja_disable && (div_q != E1LCR_D16);
        end
    end

    // ==========================================================
    // Output selection
    // master clock on carrier loss / smoothed clock on receive side
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            RECOVERED_CLOCK_OUT <= 1'b0;
            RX_DATA_OUT <= 1'b0;
            TRANSMIT_CLOCK <= 1'b0;
            TX_DATA_OUT <= 1'b0;
            RECEIVE_CARRIER_LOSS <= 1'b0;
        end else begin
            RECOVERED_CLOCK_OUT <= rcl_q ? master_clk : ja_rx ? smooth_clk_q : rec_clk_q;
            RX_DATA_OUT <= ja_rx ? ja_out_q : rx_bit_q;
            TRANSMIT_CLOCK <= ja_tx ? smooth_clk_q : TRANSMIT_CLOCK_IN;
            TX_DATA_OUT <= ja_tx ? ja_out_q : TX_DATA_IN;
            RECEIVE_CARRIER_LOSS <= rcl_q;
        end
    end

    // ==========================================================
    // Assertions
    // flag tracks divider
    a_trip_flag: assert property (@(posedge CLK) disable iff (!RSTN)
        (!ja_disable && div_q != E1LCR_D16) |=> jlt_q) else $error("trip flag missing");
    a_carrier_out: assert property (@(posedge CLK) disable iff (!RSTN)
        rcl_q |=> RECEIVE_CARRIER_LOSS) else $error("carrier loss not shown");
    a_clk_source: assert property (@(posedge CLK) disable iff (!RSTN)
        rcl_q |=> RECOVERED_CLOCK_OUT == $past(master_clk)) else $error("clock source wrong");
    a_bypass_rx: assert property (@(posedge CLK) disable iff (!RSTN)
        (ja_disable) |=> RX_DATA_OUT == $past(rx_bit_q)) else $error("bypass failed");
    a_tx_pass: assert property (@(posedge CLK) disable iff (!RSTN)
        (!ja_tx) |=> TX_DATA_OUT == $past(TX_DATA_IN)) else $error("tx pass wrong");
    a_loss_clear: assert property (@(posedge CLK) disable iff (!RSTN)
        (ovs_tick && pulse_edge) |=> !rcl_q) else $error("loss not cleared");
    a_div_range: assert property (@(posedge CLK) disable iff (!RSTN)
        div_cnt_q <= DIV_SLOW) else $error("divider out of range");
    a_fill_depth: assert property (@(posedge CLK) disable iff (!RSTN)
        (ja_depth_select && !lic_wr_q) |-> (wr_ptr_q < 7'h20) && (rd_ptr_q < 7'h20))
        else $error("pointer exceeds depth");
    c_loss: cover property (@(posedge CLK) disable iff (!RSTN) $rose(rcl_q));
    c_trip: cover property (@(posedge CLK) disable iff (!RSTN) $rose(jlt_q));
    c_write: cover property (@(posedge CLK) disable iff (!RSTN) do_write);
endmodule // e1lcr_top

// ---- bench/e1lcr_line_model.sv ----
// Behavioural E1 receive line: AMI marks on the receive pair.
// Assumes the 50 MHz bench clock; fast lifts the line rate well above nominal.
`timescale 1ns/100ps
module e1lcr_line_model (
    input wire logic clk,
    input wire logic en,
    input wire logic fast,
    output logic pos,
    output logic neg
);
    int acc = 0;
    int hold = 0;
    logic pol = 1'b0;
    // ==========================================================
    // Bit timing from a rate accumulator, marks half a bit wide
    always @(posedge clk) begin
        acc += fast ? 2300 : 2048;
        if (hold > 0) begin
            hold -= 1;
        end
        if (acc >= 50000) begin
            acc -= 50000;
            if (en) begin
                hold = 12;
                pol = !pol; // Alternate mark polarity
            end
        end
        pos <= (hold > 0) && pol;
        neg <= (hold > 0) && !pol;
    end
endmodule // e1lcr_line_model

// ---- bench/e1lcr_top_tb.sv ----
// Self-checking bench: AXI4-Lite register tasks plus line model.
// Assumes the design package and one 50 MHz clock.
`timescale 1ns/100ps
module e1lcr_top_tb;
    import e1lcr_pkg::*;
    logic clk = 0, rstn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, transmit_clock = 0, txd = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid, recovered_clock_out, rxd, tco, txo, receive_carrier_loss;
    logic line_en = 0, fast = 0, lp, ln;
    e1lcr_shape_t shape;
    logic [31:0] d;
    int err_count = 0, check_count = 0, rises, highs, k, bad;
    logic p_txd, p_transmit_clock;
    e1lcr_shape_t sh_tab [8] = '{5'h01, 5'h10, 5'h08, 5'h18, 5'h04, 5'h16, 5'h06, 5'h00};
    logic [7:0] bit_tab [3] = '{8'h08, 8'h04, 8'h02};

    e1lcr_top dut (.CLK(clk), .RSTN(rstn), .AWADDR(awaddr), .AWVALID(awvalid),
        .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
        .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .RECEIVE_LINE_POSITIVE(lp), .RECEIVE_LINE_NEGATIVE(ln), .TRANSMIT_CLOCK_IN(transmit_clock),
        .TX_DATA_IN(txd), .RECOVERED_CLOCK_OUT(recovered_clock_out), .RX_DATA_OUT(rxd),
        .TRANSMIT_CLOCK(tco), .TX_DATA_OUT(txo), .RECEIVE_CARRIER_LOSS(receive_carrier_loss),
        .WAVE_SHAPE(shape));
    e1lcr_line_model line (.clk(clk), .en(line_en), .fast(fast), .pos(lp), .neg(ln));

    // ==========================================================
    // Clock, transmit clock stimulus and watchdog
    initial begin
        forever #10 clk = !clk;
    end
    always @(posedge clk) begin
        // Gapped short-pulse transmit clock: three pulses then a gap
        transmit_clock <= ((($time / 20) % 96) < 72) && ((($time / 20) % 24) < 4);
        txd <= ($time / 480) % 3 == 0;
    end
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        test_done();
    end

    // ==========================================================
    // Compare, report and bus tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_sh(input e1lcr_shape_t e);
        check_count++;
        if (shape !== e) begin
            err_count++;
            $display("BAD wave_shape expected %h seen %h", e, shape);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (awvalid && !awready || wvalid && !wready);
        while (!bvalid) @(posedge clk);
        rs = bresp;
        bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge clk); while (!arready);
        arvalid <= 0;
        do @(posedge clk); while (!rvalid);
        v = rdata;
        rs = rresp;
        rready <= 0;
    endtask
    task automatic measure(input logic tx_sel);
        logic prev;
        logic cur;
        rises = 0;
        highs = 0;
        prev = tx_sel ? tco : recovered_clock_out;
        repeat (1000) begin
            @(posedge clk);
            cur = tx_sel ? tco : recovered_clock_out;
            highs += (cur === 1'b1);
            rises += (cur === 1'b1 && prev === 1'b0);
            prev = cur;
        end
    endtask

    // ==========================================================
    // Test sequence
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1;
        chk_sh(sh_tab[0]);
        repeat (650) @(posedge clk);
        chk("rcl_early", 0, receive_carrier_loss);
        for (k = 0; k < 300 && receive_carrier_loss !== 1'b1; k++) @(posedge clk);
        chk("rcl_set", 1, receive_carrier_loss);
        measure(1'b0);
        chk("master_rises", 1, rises >= 37 && rises <= 45);
        rd(RIR_OFFSET, d, r);
        chk("status_rcl", 32'h1, d & 32'h1);
        line_en <= 1;
        for (k = 0; k < 200 && receive_carrier_loss !== 1'b0; k++) @(posedge clk);
        chk("rcl_clear", 0, receive_carrier_loss);
        repeat (2000) @(posedge clk);
        measure(1'b0);
        chk("recovered_rises", 1, rises >= 37 && rises <= 45);
        chk("duty_high", 1, highs >= 400 && highs <= 600);
        rd(RIR_OFFSET, d, r);
        chk("status_nominal", 32'h0, d & 32'h21);
        for (k = 0; k < 8; k++) begin
            wr(LIC_OFFSET, {24'h0, k[2:0], 5'h00}, r);
            chk("lic_wresp", 0, r);
            chk_sh(sh_tab[k]);
            rd(LIC_OFFSET, d, r);
            chk("lic_bo", {24'h0, k[2:0], 5'h00}, d & 32'hee);
        end
        for (k = 0; k < 3; k++) begin
            wr(LIC_OFFSET, {24'h0, bit_tab[k]}, r);
            rd(LIC_OFFSET, d, r);
            chk("lic_bits", {24'h0, bit_tab[k]}, d & 32'hee);
            if (k == 0) begin
                measure(1'b1);
                chk("tx_smooth_rises", 1, rises >= 37 && rises <= 45);
                chk("tx_smooth_highs", 1, highs >= 400 && highs <= 600);
            end
        end
        // all three paths bypass the disabled attenuator
        bad = 0;
        @(negedge clk);
        p_txd = txd;
        p_transmit_clock = transmit_clock;
        repeat (40) begin
            @(negedge clk);
            bad += (txo !== p_txd) + (tco !== p_transmit_clock) + (rxd !== 1'b1);
            p_txd = txd;
            p_transmit_clock = transmit_clock;
        end
        chk("bypass_errors", 0, bad);
        wr(8'h20, 32'h55, r);
        chk("unmapped_wresp", 2, r);
        rd(8'h20, d, r);
        chk("unmapped_rd", 0, d);
        chk("unmapped_rresp", 2, r);
        wr(LIC_OFFSET, 32'h04, r);
        fast <= 1;
        d = 0;
        for (k = 0; k < 200 && d[5] !== 1'b1; k++) begin
            repeat (50) @(posedge clk);
            rd(RIR_OFFSET, d, r);
        end
        chk("limit_trip", 32'h20, d & 32'h20);
        test_done();
    end
endmodule // e1lcr_top_tb
